// file: pmc_ctrl.sv
// Purpose: Operating mode, clock gating and option logic of a small microcontroller
// Assumes: Software drives the halt instruction and option fuses over AXI4-Lite
// Notes:   The internal RC oscillator is seen here as a sampled pin ticking input
//
// Overview of operation
// - Without halt, run Normal: external oscillator on, RC clock on, system clock external.
// - Halt with gate bit 0 enters Idle; RC clock and oscillator stay on.
// - Halt with gate 1 and watchdog on enters Halt; RC clock off, oscillator on.
// - Halt with gate 1 and watchdog off stops every clock and oscillator.
// - RC oscillator stays disabled unless the watchdog oscillator enable is set.
// - Option clock is either the RC oscillator or system clock divided by four.
// - Watchdog counting clock is system clock divided by four or RC oscillator.
// - Watchdog enable is an option only; it decides RC oscillator in Halt.
// - Four watchdog timeout ranges, 2^12 up to 2^15 watchdog clock periods.
// - One-time clear resets watchdog at once; two-time needs both clears.
// - Buzzer output is option clock divided by 2^2 through 2^9.
// - Falling edge on a wake-enabled port A pin leaves power down.
// - Option makes the two lowest port A pins general I/O or buzzer pair.
// - External interrupt trigger: disabled, falling, rising, or either edge.
// - Gate bit 0 keeps RC clock running in halt; 1 disables it.
`timescale 1ns/1ps
module pmc_ctrl
  import pmc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  port_a_in,
  input  wire logic        irc_tick_in,
  input  wire logic        ext_int_in,
  output logic             ext_osc_en,
  output logic             sys_clk_en,
  output logic             irc_clk_en,
  output logic             irc_osc_en,
  output logic             wdog_reset,
  output logic             ext_int_pulse,
  output logic             wake_pulse,
  output logic [1:0]       buzzer_output,
  output logic [1:0]       buzzer_oe
);
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [1:0]        ctrl;
    logic [23:0]       opt;
    pmc_mode_t         mode;
    logic [1:0]        div4;
    logic              irc_prev;
    logic [PMC_DIV_W-1:0] wd_cnt;
    logic [9:0]        buz_cnt;
    logic              buz;
    logic              buz_n;
    logic              clr1_seen;
    logic              clr2_seen;
    logic              wd_rst;
    logic [7:0]        port_a_prev;
    logic              int_prev;
    logic              int_pulse;
    logic              wake;
    logic              ext_osc;
    logic              sys_en;
    logic              irc_clk;
    logic              irc_osc;
  } pmc_state_t;

  pmc_state_t s_q;
  pmc_state_t s_d;
  logic [9:0]  pin_sync;
  logic [7:0]  port_a_s;
  logic        irc_s;
  logic        int_s;

  // Pins cross into aclk through two flops each
  pmc_sync #(.W(10)) i_pmc_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({ext_int_in, irc_tick_in, port_a_in}),
    .dout    (pin_sync)
  );
  assign port_a_s = pin_sync[7:0];
  assign irc_s    = pin_sync[8];
  assign int_s    = pin_sync[9];

  // Next-state logic: bus slave, mode machine, dividers, watchdog, edges
  always_comb
  begin
    logic        halt_cmd;
    logic        clr_cmd;
    logic        clr1_cmd;
    logic        clr2_cmd;
    logic        opt_tick;
    logic        wd_tick;
    logic        sys4_tick;
    logic        irc_rise;
    logic [7:0]  port_a_fall;
    logic [3:0]  buz_sel;
    logic [4:0]  wd_sel;
    logic        wd_clear;
    logic        irc_allowed;
    s_d         = s_q;
    halt_cmd    = 1'b0;
    clr_cmd     = 1'b0;
    clr1_cmd    = 1'b0;
    clr2_cmd    = 1'b0;
    opt_tick    = 1'b0;
    wd_tick     = 1'b0;
    sys4_tick   = 1'b0;
    irc_rise    = 1'b0;
    port_a_fall = 8'h00;
    wd_clear    = 1'b0;
    irc_allowed = 1'b0;
    buz_sel     = 4'h0;
    wd_sel      = 5'h00;

    // Write channel: address and data taken in either order
    s_d.awready = 1'b0;
    s_d.wready  = 1'b0;
    if (s_axi_awvalid && !s_q.aw_got && !s_q.awready && !s_q.bvalid)
      s_d.awready = 1'b1;
    if (s_axi_wvalid && !s_q.w_got && !s_q.wready && !s_q.bvalid)
      s_d.wready = 1'b1;
    if (s_q.awready && s_axi_awvalid)
    begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = PMC_RESP_OKAY;
      case (s_q.awaddr)
        PMC_OFF_CTRL:   s_d.ctrl = s_q.wdata[1:0];
        PMC_OFF_OPT:    s_d.opt  = s_q.wdata[23:0];
        PMC_OFF_CMD:
        begin
          halt_cmd = s_q.wdata[PMC_CMD_HALT];
          clr_cmd  = s_q.wdata[PMC_CMD_CLR];
          clr1_cmd = s_q.wdata[PMC_CMD_CLR1];
          clr2_cmd = s_q.wdata[PMC_CMD_CLR2];
        end
        PMC_OFF_STATUS: ;
        default:        s_d.bresp = PMC_RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;

    // Read channel: one outstanding read, status shows live state
    s_d.arready = 1'b0;
    if (s_axi_arvalid && !s_q.arready && !s_q.rvalid)
      s_d.arready = 1'b1;
    if (s_q.arready && s_axi_arvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = PMC_RESP_OKAY;
      case (s_axi_araddr)
        PMC_OFF_CTRL:   s_d.rdata = {30'h0, s_q.ctrl};
        PMC_OFF_OPT:    s_d.rdata = {8'h00, s_q.opt};
        PMC_OFF_CMD:    s_d.rdata = 32'h0;
        PMC_OFF_STATUS: s_d.rdata = {24'h0, s_q.clr2_seen, s_q.clr1_seen,
                                     s_q.irc_osc, s_q.irc_clk, s_q.sys_en,
                                     s_q.ext_osc, 2'(s_q.mode)};
        default:
        begin
          s_d.rdata = 32'h0;
          s_d.rresp = PMC_RESP_SLVERR;
        end
      endcase
    end
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;

    // Edge detection on synchronised pins
    irc_rise     = irc_s && !s_q.irc_prev;
    s_d.irc_prev = irc_s;
    port_a_fall     = s_q.port_a_prev & ~port_a_s;
    s_d.port_a_prev = port_a_s;
    s_d.int_prev = int_s;
    case (s_q.opt[PMC_OPT_INTEDGE +: 2])
      PMC_EDGE_FALL: s_d.int_pulse = s_q.int_prev && !int_s;
      PMC_EDGE_RISE: s_d.int_pulse = !s_q.int_prev && int_s;
      PMC_EDGE_BOTH: s_d.int_pulse = s_q.int_prev != int_s;
      default:       s_d.int_pulse = 1'b0;
    endcase

    // Wake on a falling edge of an enabled port A pin, only out of power down
    s_d.wake = (s_q.mode != PMC_NORMAL) &&
               |(port_a_fall & s_q.opt[PMC_OPT_WAKE +: 8]);

    // Mode machine
    case (s_q.mode)
      PMC_NORMAL:
        if (halt_cmd)
          s_d.mode = s_q.ctrl[PMC_CTRL_GATE] ? PMC_HALT : PMC_IDLE;
      PMC_IDLE, PMC_HALT:
        if (s_q.wake || s_q.int_pulse)
          s_d.mode = PMC_NORMAL;
      default: s_d.mode = PMC_NORMAL;
    endcase

    // Clock enables follow the mode; RC oscillator needs the enable field
    irc_allowed = s_q.ctrl[PMC_CTRL_OSCEN];
    s_d.ext_osc = (s_d.mode == PMC_NORMAL);
    s_d.sys_en  = (s_d.mode == PMC_NORMAL);
    s_d.irc_clk = irc_allowed && (s_d.mode != PMC_HALT);
    s_d.irc_osc = irc_allowed &&
                  ((s_d.mode != PMC_HALT) || s_q.opt[PMC_OPT_WDEN]);

    // System clock divided by four, counted only while it runs
    sys4_tick = s_q.sys_en && (s_q.div4 == 2'h3);
    if (s_q.sys_en)
      s_d.div4 = s_q.div4 + 2'h1;
    opt_tick = s_q.opt[PMC_OPT_FSSEL] ? sys4_tick : (irc_rise && s_q.irc_osc);
    wd_tick = s_q.opt[PMC_OPT_WDCLK] ? (irc_rise && s_q.irc_osc) : sys4_tick;

    // Watchdog clear: single or paired instructions
    if (s_q.opt[PMC_OPT_CLR2])
    begin
      s_d.clr1_seen = s_q.clr1_seen || clr1_cmd;
      s_d.clr2_seen = s_q.clr2_seen || clr2_cmd;
      if (s_d.clr1_seen && s_d.clr2_seen)
      begin
        wd_clear      = 1'b1;
        s_d.clr1_seen = 1'b0;
        s_d.clr2_seen = 1'b0;
      end
    end
    else
      wd_clear = clr_cmd;

    // Watchdog counter; timeout bit is 2^(12+sel), so period lies in the range
    wd_sel     = 5'(PMC_WD_BASE_EXP) + {3'h0, s_q.opt[PMC_OPT_TOUT +: 2]};
    s_d.wd_rst = 1'b0;
    if (!s_q.opt[PMC_OPT_WDEN] || wd_clear)
      s_d.wd_cnt = '0;
    else if (wd_tick)
    begin
      s_d.wd_cnt = s_q.wd_cnt + 17'h00001;
      if (s_d.wd_cnt[wd_sel])
      begin
        s_d.wd_rst = 1'b1;
        s_d.wd_cnt = '0;
      end
    end

    // Buzzer toggles at option clock/2^(2+sel); a half period is 2^(1+sel) ticks
    buz_sel = 4'(PMC_BUZ_BASE_EXP - 1) + {1'b0, s_q.opt[PMC_OPT_BZDIV +: 3]};
    if (opt_tick)
    begin
      s_d.buz_cnt = s_q.buz_cnt + 10'h001;
      if (s_d.buz_cnt[buz_sel])
      begin
        s_d.buz     = !s_q.buz;
        s_d.buz_cnt = '0;
      end
    end
    // Inverse pin has its own flop so both pins come straight from registers
    s_d.buz_n = !s_d.buz;
  end

  // One register stage holds all state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q      <= '0;
      s_q.ctrl <= PMC_CTRL_RST;
      s_q.opt  <= PMC_OPT_RST;
      s_q.mode <= PMC_NORMAL;
      s_q.buz_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from flops
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign ext_osc_en    = s_q.ext_osc;
  assign sys_clk_en    = s_q.sys_en;
  assign irc_clk_en    = s_q.irc_clk;
  assign irc_osc_en    = s_q.irc_osc;
  assign wdog_reset    = s_q.wd_rst;
  assign ext_int_pulse = s_q.int_pulse;
  assign wake_pulse    = s_q.wake;
  // Complementary buzzer pair; pins left to port logic when option is off
  assign buzzer_output = {s_q.buz_n, s_q.buz};
  assign buzzer_oe     = {2{s_q.opt[PMC_OPT_BZEN]}};
endmodule

// file: pmc_pkg.sv
// Purpose: Shared constants and types for the power mode and clock option controller
// Assumes: AXI4-Lite register access, 32-bit data, 25 MHz aclk
// Notes:   Option fields live in one configuration register loaded by software
package pmc_pkg;
  // Register byte offsets
  localparam logic [7:0] PMC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] PMC_OFF_OPT    = 8'h04;
  localparam logic [7:0] PMC_OFF_CMD    = 8'h08;
  localparam logic [7:0] PMC_OFF_STATUS = 8'h0C;
  // Control register field positions
  localparam int PMC_CTRL_GATE    = 0;
  localparam int PMC_CTRL_OSCEN   = 1;
  // Option register field positions
  localparam int PMC_OPT_FSSEL    = 0;
  localparam int PMC_OPT_WDCLK    = 1;
  localparam int PMC_OPT_WDEN     = 2;
  localparam int PMC_OPT_TOUT     = 3;
  localparam int PMC_OPT_CLR2     = 5;
  localparam int PMC_OPT_BZDIV    = 6;
  localparam int PMC_OPT_BZEN     = 9;
  localparam int PMC_OPT_INTEDGE  = 10;
  localparam int PMC_OPT_WAKE     = 16;
  // Command register bit positions (write one to issue)
  localparam int PMC_CMD_HALT     = 0;
  localparam int PMC_CMD_CLR      = 1;
  localparam int PMC_CMD_CLR1     = 2;
  localparam int PMC_CMD_CLR2     = 3;
  // Reset values
  localparam logic [1:0]  PMC_CTRL_RST = 2'h0;
  localparam logic [23:0] PMC_OPT_RST  = 24'h000000;
  // Watchdog timeout base exponent and buzzer base exponent
  localparam int PMC_WD_BASE_EXP  = 12;
  localparam int PMC_BUZ_BASE_EXP = 2;
  localparam int PMC_DIV_W        = 17;
  // External interrupt trigger selections
  localparam logic [1:0] PMC_EDGE_OFF  = 2'h0;
  localparam logic [1:0] PMC_EDGE_FALL = 2'h1;
  localparam logic [1:0] PMC_EDGE_RISE = 2'h2;
  localparam logic [1:0] PMC_EDGE_BOTH = 2'h3;
  // AXI responses
  localparam logic [1:0] PMC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PMC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {PMC_NORMAL, PMC_IDLE, PMC_HALT} pmc_mode_t;
endpackage

// file: pmc_sync.sv
// Purpose: Two flip-flop synchroniser for a bus of asynchronous pins
// Assumes: Destination clock aclk, synchronous active-low reset
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module pmc_sync #(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pmc_sync_state_t;

  pmc_sync_state_t s_q;
  pmc_sync_state_t s_d;

  // Next stage values; the first stage feeds only the second
  always_comb
  begin
    s_d.meta   = din;
    s_d.stable = s_q.meta;
  end

  // Two stages guard against metastability on pin inputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign dout = s_q.stable;
endmodule

// file: pmc_ctrl_props.sv
// Purpose: Port assertions for the power mode and clock option controller
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound into every pmc_ctrl instance
`timescale 1ns/1ps
module pmc_ctrl_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       ext_osc_en,
  input wire logic       sys_clk_en,
  input wire logic       irc_clk_en,
  input wire logic       irc_osc_en,
  input wire logic       wdog_reset,
  input wire logic       ext_int_pulse,
  input wire logic       wake_pulse,
  input wire logic [1:0] buzzer_output,
  input wire logic [1:0] buzzer_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // External oscillator and system clock are gated as one pair
  osc_sys_a: assert property (ext_osc_en == sys_clk_en)
    else $error("osc and system enables differ");
  // A running RC clock needs its oscillator
  clk_osc_a: assert property (irc_clk_en |-> irc_osc_en)
    else $error("rc clock without oscillator");
  // Gated RC clock with live oscillator only in Halt; two cycles allow for enable skew
  gate_halt_a: assert property ((irc_osc_en && !irc_clk_en) [*2] |-> !ext_osc_en)
    else $error("rc clock gated outside halt");
  wd_pulse_a: assert property (wdog_reset |=> !wdog_reset)
    else $error("watchdog reset longer than one cycle");
  buz_pair_a: assert property (buzzer_output[1] != buzzer_output[0])
    else $error("buzzer pair not complementary");
  buz_oe_a: assert property (buzzer_oe[1] == buzzer_oe[0])
    else $error("buzzer enables split");
  // Any wake event brings the oscillator back within three cycles
  wake_run_a: assert property ((wake_pulse || ext_int_pulse) |-> ##[1:3] ext_osc_en)
    else $error("no return to normal after wake");
  aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
  r_after_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
    else $error("read answer without address handshake");
endmodule

bind pmc_ctrl pmc_ctrl_props i_pmc_ctrl_props (.aclk, .aresetn, .s_axi_awready,
  .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .ext_osc_en, .sys_clk_en, .irc_clk_en,
  .irc_osc_en, .wdog_reset, .ext_int_pulse, .wake_pulse, .buzzer_output, .buzzer_oe);

// file: test_pmc_ctrl.sv
// Purpose: Self-checking bench for the power mode and clock option controller
// Assumes: 25 MHz aclk; this bench is the AXI4-Lite master
// Notes:   Read answers are matched against a queue of expected words
`timescale 1ns/1ps
module test_pmc_ctrl;
  import pmc_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, irc_tick_in, ext_int_in, ext_osc_en, sys_clk_en, irc_clk_en;
  logic        irc_osc_en, wdog_reset, ext_int_pulse, wake_pulse, tick_on;
  logic [1:0]  s_axi_bresp, s_axi_rresp, buzzer_output, buzzer_oe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, port_a_in;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [33:0] exp_q [$], exp_b [$];
  int          failures, num_checks, n_wake, n_int;
  pmc_ctrl i_pmc_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_in, .irc_tick_in,
    .ext_int_in, .ext_osc_en, .sys_clk_en, .irc_clk_en, .irc_osc_en, .wdog_reset,
    .ext_int_pulse, .wake_pulse, .buzzer_output, .buzzer_oe);
  // Clock; the RC tick stands still until enabled, giving a tick every two cycles
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) irc_tick_in <= tick_on ? ~irc_tick_in : irc_tick_in;
  task end_of_test(input bit hung);
  begin
    failures = failures + hung;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
  begin
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write: address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    int         n;
    logic [1:0] r;
  begin
    n = 0;
    // Mapped offsets answer OKAY, anything else SLVERR
    r = PMC_RESP_SLVERR;
    if (a inside {PMC_OFF_CTRL, PMC_OFF_OPT, PMC_OFF_CMD, PMC_OFF_STATUS}) r = PMC_RESP_OKAY;
    exp_b.push_back({32'h0, r});
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) end_of_test(1);
  end
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    int n;
  begin
    n = 0;
    exp_q.push_back(e);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    if (n >= 50) end_of_test(1);
  end
  endtask
  // Cycles until the buzzer changes, or until the watchdog fires
  task meas(input bit buz, output int c);
    logic b;
  begin
    b = buzzer_output[0];
    c = 0;
    do
    begin
      @(posedge aclk);
      c++;
    end while ((buz ? buzzer_output[0] === b : wdog_reset !== 1'b1) && c < 20000);
    if (c >= 20000) end_of_test(1);
  end
  endtask
  // Read and write answers meet the oldest note; pulse counters for wake and interrupt
  always @(posedge aclk)
  begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      chk("write resp", exp_b.pop_front(), {32'h0, s_axi_bresp});
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk("read", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    n_wake <= n_wake + (wake_pulse === 1'b1);
    n_int  <= n_int + (ext_int_pulse === 1'b1);
  end
  initial
  begin
    int          c;
    logic [15:0] tab [5];
    logic [7:0]  m;
    // Per row: control bits, watchdog enable, status expected after halt
    tab = '{16'h2031, 16'h3122, 16'h3002, 16'h1102, 16'h0101};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, irc_tick_in, ext_int_in, tick_on} = '0;
    {failures, num_checks, n_wake, n_int} = '0;
    port_a_in = 8'hFF;
    aresetn   = 1'b0;
    void'($urandom(16120));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk("buzzer reset", 34'h2, {30'h0, buzzer_oe, buzzer_output});
    rd(PMC_OFF_STATUS, 34'h0C);
    rd(8'h10, {PMC_RESP_SLVERR, 32'h0});
    wr(8'h10, 32'h0);
    // Each halt branch; unmasked pins must not wake, a masked pin must
    foreach (tab[i])
    begin
      m = 8'h1 << ($urandom % 8);
      wr(PMC_OFF_CTRL, {30'h0, tab[i][13:12]});
      wr(PMC_OFF_OPT, {8'h0, m, 13'h0, tab[i][8], 2'h2});
      wr(PMC_OFF_CMD, 32'h1);
      cyc(3);
      rd(PMC_OFF_STATUS, {26'h0, tab[i][7:0]});
      chk("enables", 34'(tab[i][5:2]), 34'({irc_osc_en, irc_clk_en, sys_clk_en, ext_osc_en}));
      port_a_in <= m;
      cyc(6);
      rd(PMC_OFF_STATUS, {26'h0, tab[i][7:0]});
      port_a_in <= 8'h00;
      cyc(6);
      rd(PMC_OFF_STATUS, {26'h0, tab[i][13] ? 8'h3C : 8'h0C});
      chk("wakes", 34'(i + 1), 34'(n_wake));
      port_a_in <= 8'hFF;
    end
    for (int e = 0; e < 4; e++)
    begin
      c = n_int;
      wr(PMC_OFF_OPT, 32'(e) << PMC_OPT_INTEDGE);
      ext_int_in <= 1'b1;
      cyc(6);
      ext_int_in <= 1'b0;
      cyc(6);
      chk("int edges", 34'(c + e[0] + e[1]), 34'(n_int));
    end
    // Skip the first change and one transitional half period after a divider switch
    for (int s = 0; s < 8; s++)
    begin
      wr(PMC_OFF_OPT, 32'h201 | (32'(s) << PMC_OPT_BZDIV));
      repeat (2) meas(1, c);
      meas(1, c);
      chk("buzzer half", 34'(8 << s), 34'(c));
      chk("buzzer oe", 34'h3, 34'(buzzer_oe));
    end
    wr(PMC_OFF_CTRL, 32'h2);
    tick_on <= 1'b1;
    wr(PMC_OFF_OPT, 32'h6);
    // RC ticks every two cycles: a buzzer half period is two option clock ticks
    repeat (2) meas(1, c);
    meas(1, c);
    chk("buzzer rc", 34'h4, 34'(c));
    // Count runs well before the clear, so an ignored clear would fire early
    cyc(2000);
    wr(PMC_OFF_CMD, 32'h2);
    meas(0, c);
    chk("wdog rc", 34'h1, 34'(c inside {[8180:8220]}));
    // Both clears at once restart; a lone first clear later must not restart
    wr(PMC_OFF_OPT, 32'h24);
    wr(PMC_OFF_CMD, 32'hC);
    cyc(6000);
    wr(PMC_OFF_CMD, 32'h4);
    meas(0, c);
    chk("wdog lone", 34'h1, 34'(c inside {[10360:10400]}));
    wr(PMC_OFF_CMD, 32'h8);
    meas(0, c);
    chk("wdog two", 34'h1, 34'(c inside {[16370:16410]}));
    end_of_test(0);
  end
endmodule
